// ===== cpusr_pkg.sv
// Package for the CPU state and register bank block.
// Assumes one core clock and one asynchronous active-high reset.
package cpusr_pkg;

  // ----------------------------------------------------------------
  // Status word layout and reset
  // ----------------------------------------------------------------
  localparam int          PSW_IE_BIT   = 7;
  localparam int          PSW_Z_BIT    = 6;
  localparam int          PSW_BANK_SELECT_BIT_HIGH_BIT = 5;
  localparam int          PSW_AC_BIT   = 4;
  localparam int          PSW_BANK_SELECT_BIT_LOW_BIT = 3;
  localparam int          PSW_ISP_BIT  = 1;
  localparam int          PSW_CY_BIT   = 0;
  localparam logic [7:0]  PSW_RESET    = 8'h02;

  // ----------------------------------------------------------------
  // Memory map
  // ----------------------------------------------------------------
  localparam logic [15:0] GREG_BASE    = 16'hfee0;
  localparam logic [15:0] GREG_LAST    = 16'hfeff;
  localparam logic [15:0] SFR_BASE     = 16'hff00;
  localparam logic [15:0] EXT_HOLE_LO  = 16'hffd0;
  localparam logic [15:0] EXT_HOLE_HI  = 16'hffdf;
  localparam logic [15:0] SERIAL_ADDR  = 16'hff18;
  localparam logic [15:0] IRQ_REQ_LOW_ADDR   = 16'hffe0;
  localparam logic [15:0] IRQ_REQ_HIGH_ADDR  = 16'hffe1;
  localparam logic [15:0] IRQ_REQ_EXT_ADDR   = 16'hffe2;
  localparam logic [15:0] IRQ_MASK_LOW_ADDR  = 16'hffe4;
  localparam logic [15:0] IRQ_MASK_HIGH_ADDR = 16'hffe5;
  localparam logic [15:0] IRQ_MASK_EXT_ADDR  = 16'hffe6;
  localparam logic [15:0] IRQ_LVL_LOW_ADDR   = 16'hffe8;
  localparam logic [15:0] IRQ_LVL_HIGH_ADDR  = 16'hffe9;
  localparam logic [15:0] IRQ_LVL_EXT_ADDR   = 16'hffea;
  localparam logic [15:0] MEM_SIZE_ADDR      = 16'hfff0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  IRQ_REQ_RESET  = 8'h00;
  localparam logic [7:0]  IRQ_MASK_RESET = 8'hff;
  localparam logic [7:0]  IRQ_LVL_RESET  = 8'hff;
  localparam logic [7:0]  MEM_SIZE_RESET = 8'hcf;
  localparam logic [7:0]  RX_BUF_RESET   = 8'hff;
  localparam logic [7:0]  TX_SHIFT_RESET = 8'hff;
  localparam logic [15:0] SP_RESET       = 16'h0000;
  localparam int          IRQ_SOURCES    = 24;

  // ----------------------------------------------------------------
  // Access widths and core-side carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CPUSR_W_BIT  = 2'b00,
    CPUSR_W_BYTE = 2'b01,
    CPUSR_W_WORD = 2'b11
  } cpusr_width_t;

  typedef struct packed {
    logic         valid;
    logic         write;
    logic         direct;   // Direct addressing, not the SFR mode
    cpusr_width_t width;
    logic [2:0]   bit_sel;
    logic [15:0]  addr;
    logic [15:0]  wdata;
  } cpusr_mem_req_t;

  typedef struct packed {
    logic        stack_push;    // Status word push or interrupt entry
    logic        stack_pop;     // Pop, return from irq or break
    logic        irq_block;
    logic        irq_unblock;
    logic        irq_ack;
    logic        nmi_ack;
    logic        bank_switch;
    logic [1:0]  bank_num;
    logic        flags_we;
    logic [7:0]  result;
    logic        half_carry;
    logic        carry;
    logic        sp_load;
    logic [15:0] sp_value;
  } cpusr_ctl_t;

  // Byte offset of a general register inside the bank area.
  function automatic logic [4:0] cpusr_greg_off(input logic [1:0] bank,
                                                input logic [2:0] rnum);
    cpusr_greg_off = {~bank, rnum};
  endfunction : cpusr_greg_off

endpackage : cpusr_pkg

// ===== cpusr_core_state.sv
// CPU state: status word, stack pointer, register banks and SFR decode.
// Assumes the instruction sequencer drives one control word per cycle
// and one memory request at a time; all inputs share core_clk.
// The stack pointer reads 0000h after reset; software must load it.
// Unknown SFR addresses answer with access_err and read as zero.
`timescale 1ns/10ps
`default_nettype none

module cpusr_core_state
  import cpusr_pkg::*;
(
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst,
  // Sequencer control
  input  wire cpusr_ctl_t      ctl,
  // Register and SFR access
  input  wire cpusr_mem_req_t  mem_req,
  input  wire logic [1:0]      greg_bank_rd,
  input  wire logic [2:0]      greg_num_rd,
  // Interrupt sources and receive data
  input  wire logic [23:0]     irq_raise,
  input  wire logic            nmi_req,
  input  wire logic            rx_load,
  input  wire logic [7:0]      rx_data,
  // Stack traffic to RAM
  output logic                 stack_wr,
  output logic                 stack_rd,
  output logic [15:0]          stack_addr,
  output logic [7:0]           stack_wdata,
  input  wire logic [7:0]      stack_rdata,
  // State outputs
  output logic [7:0]           psw_out,
  output logic [15:0]          sp_out,
  output logic [15:0]          rdata,
  output logic                 access_err,
  output logic                 ext_access,
  output logic [15:0]          ext_addr,
  output logic [7:0]           tx_data,
  output logic                 tx_start,
  output logic                 irq_take,
  output logic                 nmi_take,
  output logic [4:0]           irq_source,
  output logic [7:0]           mem_size_out,
  output logic [15:0]          greg_pair_rd
);

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  logic [7:0]  psw_reg;
  logic [15:0] sp_reg;
  logic [23:0] req_reg;
  logic [23:0] mask_reg;
  logic [23:0] lvl_reg;
  logic [7:0]  mem_size_reg;
  logic [7:0]  rx_reg;
  logic [7:0]  greg_mem [0:31];
  logic        pop_pending_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic [15:0] a        = mem_req.addr;
  wire logic        in_greg  = (a >= GREG_BASE) && (a <= GREG_LAST);
  wire logic        in_sfr   = (a >= SFR_BASE);
  wire logic        in_hole  = (a >= EXT_HOLE_LO) && (a <= EXT_HOLE_HI);
  wire logic        is_word  = (mem_req.width == CPUSR_W_WORD);
  wire logic        is_bit   = (mem_req.width == CPUSR_W_BIT);
  wire logic [4:0]  g_off    = a[4:0];

  // ----------------------------------------------------------------
  // SFR select
  // ----------------------------------------------------------------
  // Only the interrupt flag, size and serial cells live in this block.
  // Which widths each implemented SFR accepts
  wire logic sel_req_l  = (a == IRQ_REQ_LOW_ADDR);
  wire logic sel_req_h  = (a == IRQ_REQ_HIGH_ADDR);
  wire logic sel_req_x  = (a == IRQ_REQ_EXT_ADDR);
  wire logic sel_msk_l  = (a == IRQ_MASK_LOW_ADDR);
  wire logic sel_msk_h  = (a == IRQ_MASK_HIGH_ADDR);
  wire logic sel_msk_x  = (a == IRQ_MASK_EXT_ADDR);
  wire logic sel_lvl_l  = (a == IRQ_LVL_LOW_ADDR);
  wire logic sel_lvl_h  = (a == IRQ_LVL_HIGH_ADDR);
  wire logic sel_lvl_x  = (a == IRQ_LVL_EXT_ADDR);
  wire logic sel_msz    = (a == MEM_SIZE_ADDR);
  wire logic sel_ser    = (a == SERIAL_ADDR);
  wire logic word_ok    = sel_req_l || sel_msk_l || sel_lvl_l;
  wire logic known_sfr  = sel_req_l || sel_req_h || sel_req_x ||
                          sel_msk_l || sel_msk_h || sel_msk_x ||
                          sel_lvl_l || sel_lvl_h || sel_lvl_x ||
                          sel_msz || sel_ser;

  // Width legality: word only on even pair bases, no bits on size/serial
  wire logic width_bad =
    (is_word && (a[0] || (in_sfr && !word_ok))) ||
    (is_bit && (sel_msz || sel_ser));
  // The hole is external only when direct addressing is used
  wire logic hole_bad  = in_hole && !mem_req.direct;
  wire logic req_ok    = mem_req.valid && !width_bad && !hole_bad;
  wire logic wr_ok     = req_ok && mem_req.write;

  // Bit writes touch one bit of the old byte
  function automatic logic [7:0] merge_bit(input logic [7:0] old,
                                           input logic [2:0] pos,
                                           input logic       val);
    logic [7:0] tmp;
    tmp      = old;
    tmp[pos] = val;
    merge_bit = tmp;
  endfunction : merge_bit

  // Byte write data: upper half for the odd byte of a word
  function automatic logic [7:0] wr_byte(input logic [7:0] old,
                                         input logic       hi);
    if (is_bit)
      wr_byte = merge_bit(old, mem_req.bit_sel, mem_req.wdata[0]);
    else if (hi)
      wr_byte = mem_req.wdata[15:8];
    else
      wr_byte = mem_req.wdata[7:0];
  endfunction : wr_byte

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // Word access to a low SFR also writes the odd partner byte
  wire logic w_req_l = wr_ok && sel_req_l;
  wire logic w_req_h = wr_ok && (sel_req_h || (sel_req_l && is_word));
  wire logic w_req_x = wr_ok && sel_req_x;
  wire logic w_msk_l = wr_ok && sel_msk_l;
  wire logic w_msk_h = wr_ok && (sel_msk_h || (sel_msk_l && is_word));
  wire logic w_msk_x = wr_ok && sel_msk_x;
  wire logic w_lvl_l = wr_ok && sel_lvl_l;
  wire logic w_lvl_h = wr_ok && (sel_lvl_h || (sel_lvl_l && is_word));
  wire logic w_lvl_x = wr_ok && sel_lvl_x;

  // ----------------------------------------------------------------
  // Interrupt acceptance
  // ----------------------------------------------------------------
  // A source is a candidate when requested and unmasked; with the
  // service level flag clear only high-priority (level bit 0) qualify.
  wire logic [23:0] cand = req_reg & ~mask_reg &
                           (psw_reg[PSW_ISP_BIT] ? 24'hffffff
                                                 : ~lvl_reg);
  // Lowest source index wins; a pending NMI suppresses irq_take.
  logic [4:0] pick;
  logic       any_cand;
  always_comb begin
    pick     = 5'd0;
    any_cand = 1'b0;
    for (int i = IRQ_SOURCES - 1; i >= 0; i--) begin
      if (cand[i]) begin
        pick     = 5'(i);
        any_cand = 1'b1;
      end
    end
  end
  wire logic mask_take = psw_reg[PSW_IE_BIT] && any_cand;

  // ----------------------------------------------------------------
  // Status word next value
  // ----------------------------------------------------------------
  // A pop reload lands first so same-cycle flag updates still apply.
  logic [7:0] psw_next;
  always_comb begin
    psw_next = psw_reg;
    if (pop_pending_reg)
      psw_next = stack_rdata;
    if (ctl.flags_we) begin
      psw_next[PSW_Z_BIT]  = (ctl.result == 8'h00);
      psw_next[PSW_AC_BIT] = ctl.half_carry;
      psw_next[PSW_CY_BIT] = ctl.carry;
    end
    if (ctl.bank_switch) begin
      psw_next[PSW_BANK_SELECT_BIT_HIGH_BIT] = ctl.bank_num[1];
      psw_next[PSW_BANK_SELECT_BIT_LOW_BIT] = ctl.bank_num[0];
    end
    if (ctl.irq_unblock)
      psw_next[PSW_IE_BIT] = 1'b1;
    if (ctl.irq_block || ctl.irq_ack || ctl.nmi_ack)
      psw_next[PSW_IE_BIT] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------
  // Stack: pre-decrement on push, read then increment on pop
  wire logic [15:0] sp_dec = sp_reg - 16'h0001;
  wire logic [15:0] sp_inc = sp_reg + 16'h0001;
  wire logic        push_ev = ctl.stack_push || ctl.irq_ack || ctl.nmi_ack;

  // A load beats push and pop in the same cycle
  logic [15:0] sp_next;
  always_comb begin
    sp_next = sp_reg;
    if (ctl.sp_load)
      sp_next = ctl.sp_value;
    else if (push_ev)
      sp_next = sp_dec;
    else if (ctl.stack_pop)
      sp_next = sp_inc;
  end

  // ----------------------------------------------------------------
  // Clocked state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      psw_reg         <= PSW_RESET;
      sp_reg          <= SP_RESET;
      pop_pending_reg <= 1'b0;
    end else begin
      psw_reg         <= psw_next;
      pop_pending_reg <= ctl.stack_pop && !ctl.sp_load;
      sp_reg          <= sp_next;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_reg      <= {3{IRQ_REQ_RESET}};
      mask_reg     <= {3{IRQ_MASK_RESET}};
      lvl_reg      <= {3{IRQ_LVL_RESET}};
      mem_size_reg <= MEM_SIZE_RESET;
      rx_reg       <= RX_BUF_RESET;
    end else begin
      req_reg[7:0]   <= (w_req_l ? wr_byte(req_reg[7:0], 1'b0)
                                 : req_reg[7:0]) | irq_raise[7:0];
      req_reg[15:8]  <= (w_req_h ? wr_byte(req_reg[15:8], is_word)
                                 : req_reg[15:8]) | irq_raise[15:8];
      req_reg[23:16] <= (w_req_x ? wr_byte(req_reg[23:16], 1'b0)
                                 : req_reg[23:16]) | irq_raise[23:16];
      if (w_msk_l) mask_reg[7:0]   <= wr_byte(mask_reg[7:0], 1'b0);
      if (w_msk_h) mask_reg[15:8]  <= wr_byte(mask_reg[15:8], is_word);
      if (w_msk_x) mask_reg[23:16] <= wr_byte(mask_reg[23:16], 1'b0);
      if (w_lvl_l) lvl_reg[7:0]    <= wr_byte(lvl_reg[7:0], 1'b0);
      if (w_lvl_h) lvl_reg[15:8]   <= wr_byte(lvl_reg[15:8], is_word);
      if (w_lvl_x) lvl_reg[23:16]  <= wr_byte(lvl_reg[23:16], 1'b0);
      if (wr_ok && sel_msz)
        mem_size_reg <= mem_req.wdata[7:0];
      if (rx_load)
        rx_reg <= rx_data;
    end
  end

  // ----------------------------------------------------------------
  // Register banks
  // ----------------------------------------------------------------
  // Register banks live in a small array without reset, like RAM
  // Contents are undefined until software writes them.
  always_ff @(posedge core_clk) begin
    if (wr_ok && in_greg) begin
      if (is_word) begin
        greg_mem[{g_off[4:1], 1'b0}] <= mem_req.wdata[7:0];
        greg_mem[{g_off[4:1], 1'b1}] <= mem_req.wdata[15:8];
      end else begin
        greg_mem[g_off] <= wr_byte(greg_mem[g_off], 1'b0);
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Odd byte of a word pair sits in the upper half of rdata.
  // Bit reads return the selected bit in rdata[0].
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (in_greg)
      rd_mux = is_word ? {greg_mem[{g_off[4:1], 1'b1}],
                          greg_mem[{g_off[4:1], 1'b0}]}
                       : {8'h00, greg_mem[g_off]};
    else if (sel_req_l || sel_req_h)
      rd_mux = is_word ? req_reg[15:0]
                       : {8'h00, a[0] ? req_reg[15:8] : req_reg[7:0]};
    else if (sel_msk_l || sel_msk_h)
      rd_mux = is_word ? mask_reg[15:0]
                       : {8'h00, a[0] ? mask_reg[15:8] : mask_reg[7:0]};
    else if (sel_lvl_l || sel_lvl_h)
      rd_mux = is_word ? lvl_reg[15:0]
                       : {8'h00, a[0] ? lvl_reg[15:8] : lvl_reg[7:0]};
    else if (sel_req_x)
      rd_mux = {8'h00, req_reg[23:16]};
    else if (sel_msk_x)
      rd_mux = {8'h00, mask_reg[23:16]};
    else if (sel_lvl_x)
      rd_mux = {8'h00, lvl_reg[23:16]};
    else if (sel_msz)
      rd_mux = {8'h00, mem_size_reg};
    else if (sel_ser)
      rd_mux = {8'h00, rx_reg};
  end
  wire logic [15:0] rd_sel = is_bit ? {15'h0000, rd_mux[mem_req.bit_sel]}
                                    : rd_mux;

  wire logic [4:0] pair_off = cpusr_greg_off(greg_bank_rd,
                                             {greg_num_rd[1:0], 1'b0});

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Every output is a flop so the sequencer sees no decode glitches.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stack_wr     <= 1'b0;
      stack_rd     <= 1'b0;
      stack_addr   <= 16'h0000;
      stack_wdata  <= 8'h00;
      psw_out      <= PSW_RESET;
      sp_out       <= SP_RESET;
      rdata        <= 16'h0000;
      access_err   <= 1'b0;
      ext_access   <= 1'b0;
      ext_addr     <= 16'h0000;
      tx_data      <= TX_SHIFT_RESET;
      tx_start     <= 1'b0;
      irq_take     <= 1'b0;
      nmi_take     <= 1'b0;
      irq_source   <= 5'd0;
      mem_size_out <= MEM_SIZE_RESET;
      greg_pair_rd <= 16'h0000;
    end else begin
      stack_wr     <= push_ev;
      stack_rd     <= ctl.stack_pop;
      stack_addr   <= push_ev ? sp_dec : sp_reg;
      stack_wdata  <= psw_reg;
      psw_out      <= psw_next;
      sp_out       <= sp_next;
      rdata        <= req_ok && !mem_req.write ? rd_sel : 16'h0000;
      access_err   <= mem_req.valid && (width_bad || hole_bad ||
                      (in_sfr && !in_hole && !known_sfr));
      ext_access   <= req_ok && in_hole;
      ext_addr     <= (req_ok && in_hole) ? a : 16'h0000;
      tx_start     <= wr_ok && sel_ser;
      if (wr_ok && sel_ser)
        tx_data    <= mem_req.wdata[7:0];
      nmi_take     <= nmi_req;
      irq_take     <= mask_take && !nmi_req;
      irq_source   <= pick;
      mem_size_out <= (wr_ok && sel_msz) ? mem_req.wdata[7:0]
                                         : mem_size_reg;
      greg_pair_rd <= {greg_mem[pair_off + 5'd1], greg_mem[pair_off]};
    end
  end

endmodule : cpusr_core_state

`default_nettype wire

// ===== cpusr_core_state_properties.sv
// Port assertions for the CPU state block.
// Bound to cpusr_core_state; one clock domain, async reset.
`timescale 1ns/10ps
`default_nettype none
module cpusr_core_state_properties
  import cpusr_pkg::*;
(
  // Clock and reset
  input wire logic           core_clk,
  input wire logic           rst,
  // Requests
  input wire cpusr_ctl_t     ctl,
  input wire cpusr_mem_req_t mem_req,
  input wire logic [7:0]     stack_rdata,
  // Answers
  input wire logic           stack_wr,
  input wire logic           stack_rd,
  input wire logic [15:0]    stack_addr,
  input wire logic [7:0]     psw_out,
  input wire logic [15:0]    sp_out,
  input wire logic           access_err,
  input wire logic           ext_access,
  input wire logic           irq_take,
  input wire logic [7:0]     mem_size_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic hole = mem_req.valid && mem_req.addr[15:4] == 12'hffd &&
                    mem_req.width != CPUSR_W_WORD;
  wire logic push = ctl.stack_push || ctl.irq_ack || ctl.nmi_ack;

  a_reset_values: assert property (
    $fell(rst) |-> psw_out == 8'h02 && mem_size_out == 8'hcf)
    else $error("status or size register wrong after reset");
  a_unblock_sets: assert property (
    ctl.irq_unblock && !ctl.irq_block && !push |=> psw_out[PSW_IE_BIT])
    else $error("enable flag not set by unblock");
  a_block_clears: assert property (
    ctl.irq_block || ctl.irq_ack || ctl.nmi_ack |=> !psw_out[PSW_IE_BIT])
    else $error("enable flag not cleared");
  a_flag_update: assert property (
    ctl.flags_we |=> psw_out[PSW_Z_BIT] == ($past(ctl.result) == 8'h00)
      && psw_out[PSW_AC_BIT] == $past(ctl.half_carry)
      && psw_out[PSW_CY_BIT] == $past(ctl.carry))
    else $error("arithmetic flags wrong");
  a_bank_select: assert property (
    ctl.bank_switch |=> {psw_out[5], psw_out[3]} == $past(ctl.bank_num))
    else $error("bank select field wrong");
  a_push_order: assert property (
    push && !ctl.sp_load && !ctl.stack_pop |=> stack_wr
      && stack_addr == $past(sp_out) - 16'h0001 && sp_out == stack_addr)
    else $error("push not pre-decremented");
  a_pop_order: assert property (
    ctl.stack_pop && !ctl.sp_load && !push |=> stack_rd
      && stack_addr == $past(sp_out) && sp_out == stack_addr + 16'h0001)
    else $error("pop not post-incremented");
  a_pop_reload: assert property (
    stack_rd && ctl == '0 |=> psw_out == $past(stack_rdata))
    else $error("status word not restored by pop");
  a_irq_masked: assert property (
    !psw_out[PSW_IE_BIT] && !ctl.irq_unblock |=> !irq_take)
    else $error("maskable interrupt taken while disabled");
  a_word_odd: assert property (
    mem_req.valid && mem_req.width == CPUSR_W_WORD && mem_req.addr[0]
      |=> access_err)
    else $error("odd word access not refused");
  a_hole_route: assert property (
    hole |=> ext_access == $past(mem_req.direct)
      && access_err == !$past(mem_req.direct))
    else $error("external hole routed wrongly");
endmodule : cpusr_core_state_properties

bind cpusr_core_state cpusr_core_state_properties u_props (
  .core_clk, .rst, .ctl, .mem_req, .stack_rdata, .stack_wr, .stack_rd,
  .stack_addr, .psw_out, .sp_out, .access_err, .ext_access, .irq_take,
  .mem_size_out);
`default_nettype wire

// ===== cpusr_stack_ram.sv
// Stack RAM model on the far side of the stack port.
// Answers a pop in the cycle that stack_rd is high.
`timescale 1ns/10ps
`default_nettype none
module cpusr_stack_ram
  import cpusr_pkg::*;
(
  // Clock
  input  wire logic        core_clk,
  // Stack port
  input  wire logic        stack_wr,
  input  wire logic        stack_rd,
  input  wire logic [15:0] stack_addr,
  input  wire logic [7:0]  stack_wdata,
  output logic [7:0]       stack_rdata
);
  logic [7:0] ram_mem [0:1023];
  logic [7:0] last_reg = 8'h00;
  // FB00h-FEFFh fill the 1024 bytes here; other stack addresses alias into them by their low 10 bits
  wire logic [9:0] ram_idx = stack_addr[9:0] - 10'h300;
  // Idle port shows the inverse of the last byte, never a stale match
  assign stack_rdata = stack_rd ? ram_mem[ram_idx] : ~last_reg;
  always @(posedge core_clk) begin
    if (stack_wr) ram_mem[ram_idx] <= stack_wdata;
    if (stack_rd) last_reg <= ram_mem[ram_idx];
  end
endmodule : cpusr_stack_ram
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the CPU state block.
// Drives the sequencer side; a RAM model answers stack traffic.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cpusr_pkg::*;
  logic core_clk, rst, nmi_req, rx_load, stack_wr, stack_rd, access_err;
  logic ext_access, tx_start, irq_take, nmi_take;
  cpusr_ctl_t ctl;
  cpusr_mem_req_t mem_req;
  logic [1:0] greg_bank_rd;
  logic [2:0] greg_num_rd;
  logic [23:0] irq_raise;
  logic [4:0] irq_source;
  logic [7:0] rx_data, stack_rdata, stack_wdata, psw_out, tx_data;
  logic [7:0] mem_size_out;
  logic [15:0] stack_addr, sp_out, rdata, ext_addr, greg_pair_rd;
  int error_cnt = 0;
  int comparisons = 0;

  cpusr_core_state u_dut (.core_clk, .rst, .ctl, .mem_req, .greg_bank_rd,
    .greg_num_rd, .irq_raise, .nmi_req, .rx_load, .rx_data, .stack_wr,
    .stack_rd, .stack_addr, .stack_wdata, .stack_rdata, .psw_out, .sp_out,
    .rdata, .access_err, .ext_access, .ext_addr, .tx_data, .tx_start,
    .irq_take, .nmi_take, .irq_source, .mem_size_out, .greg_pair_rd);
  cpusr_stack_ram u_ram (.core_clk, .stack_wr, .stack_rd, .stack_addr,
    .stack_wdata, .stack_rdata);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic pulse(input cpusr_ctl_t c);
    ctl = c;
    step();
    ctl = '0;
  endtask : pulse
  task automatic acc(input logic w, input cpusr_width_t wd, input logic dir,
                     input logic [15:0] a, input logic [15:0] d);
    mem_req = '{valid:1'b1, write:w, direct:dir, width:wd, bit_sel:3'h0,
                addr:a, wdata:d};
    step();
    mem_req = '0;
  endtask : acc
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, CPUSR_W_BYTE, 1'b0, a, 16'h0000);
    chk(16'(rdata[7:0]), 16'(e));
  endtask : rd

  task automatic t_reset();
    logic [15:0] a [7] = '{16'hffe0, 16'hffe1, 16'hffe2, 16'hffe6,
                           16'hffea, 16'hfff0, 16'hff18};
    logic [7:0]  e [7] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hcf, 8'hff};
    chk(16'(psw_out), 16'h0002);
    chk(16'(mem_size_out), 16'h00cf);
    for (int i = 0; i < 7; i++) begin
      rd(a[i], e[i]);
    end
  endtask : t_reset
  task automatic t_status();
    pulse('{flags_we:1'b1, half_carry:1'b1, carry:1'b1, default:0});
    chk(16'(psw_out), 16'h0053);
    pulse('{flags_we:1'b1, result:8'h80, default:0});
    chk(16'(psw_out), 16'h0002);
    for (int b = 0; b < 4; b++) begin
      pulse('{bank_switch:1'b1, bank_num:2'(b), default:0});
      chk(16'({psw_out[5], psw_out[3]}), 16'(b));
    end
    pulse('{irq_unblock:1'b1, default:0});
    chk(16'(psw_out[7]), 16'h0001);
    pulse('{irq_block:1'b1, default:0});
    chk(16'(psw_out[7]), 16'h0000);
  endtask : t_status
  task automatic t_stack();
    pulse('{sp_load:1'b1, sp_value:16'hfe00, default:0});
    pulse('{stack_push:1'b1, default:0});
    chk(sp_out, 16'hfdff);
    chk({stack_wr, stack_addr[14:0]}, 16'hfdff);
    pulse('{flags_we:1'b1, default:0});
    pulse('{stack_pop:1'b1, default:0});
    chk(sp_out, 16'hfe00);
    step();
    chk(16'(psw_out), 16'h002a);
  endtask : t_stack
  task automatic t_sfr();
    acc(1'b1, CPUSR_W_WORD, 1'b0, 16'hffe4, 16'h12f7);
    rd(16'hffe4, 8'hf7);
    rd(16'hffe5, 8'h12);
    acc(1'b1, CPUSR_W_WORD, 1'b0, 16'hffe5, 16'h0000);
    chk(16'(access_err), 16'h0001);
    rd(16'hffe5, 8'h12);
    acc(1'b1, CPUSR_W_BYTE, 1'b0, 16'hffd4, 16'h0000);
    chk(16'({access_err, ext_access}), 16'h0002);
    acc(1'b0, CPUSR_W_BYTE, 1'b1, 16'hffd4, 16'h0000);
    chk(ext_addr, 16'hffd4);
    acc(1'b1, CPUSR_W_BYTE, 1'b0, 16'hff18, 16'h0033);
    chk({7'h00, tx_start, tx_data}, 16'h0133);
    rd(16'hff18, 8'hff);
    rx_load = 1'b1;
    rx_data = 8'h5a;
    step();
    rx_load = 1'b0;
    rd(16'hff18, 8'h5a);
  endtask : t_sfr
  task automatic t_greg();
    acc(1'b1, CPUSR_W_BYTE, 1'b1, 16'hfef8, 16'h0011);
    acc(1'b1, CPUSR_W_BYTE, 1'b1, 16'hfef9, 16'h0022);
    acc(1'b1, CPUSR_W_BYTE, 1'b1, 16'hfee6, 16'h0044);
    acc(1'b1, CPUSR_W_BYTE, 1'b1, 16'hfee7, 16'h0033);
    step();
    chk(greg_pair_rd, 16'h2211);
    greg_bank_rd = 2'h3;
    greg_num_rd = 3'h3;
    step();
    chk(greg_pair_rd, 16'h3344);
  endtask : t_greg
  task automatic t_irq();
    acc(1'b1, CPUSR_W_BYTE, 1'b0, 16'hffe8, 16'h00f7);
    irq_raise = 24'h000008;
    step();
    irq_raise = '0;
    step();
    chk(16'(irq_take), 16'h0000);
    rd(16'hffe0, 8'h08);
    pulse('{irq_unblock:1'b1, default:0});
    step();
    chk({irq_take, 10'h000, irq_source}, 16'h8003);
    pulse('{irq_ack:1'b1, default:0});
    step();
    chk(16'(irq_take), 16'h0000);
    nmi_req = 1'b1;
    step();
    step();
    chk(16'(nmi_take), 16'h0001);
    nmi_req = 1'b0;
  endtask : t_irq

  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  initial begin
    rst = 1'b1;
    ctl = '0;
    mem_req = '0;
    greg_bank_rd = '0;
    greg_num_rd = '0;
    irq_raise = '0;
    nmi_req = 1'b0;
    rx_load = 1'b0;
    rx_data = '0;
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    t_reset();
    t_status();
    t_stack();
    t_sfr();
    t_greg();
    t_irq();
    end_of_test();
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    error_cnt++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
